// ===== logic/cic_evt_status.sv
// sticky event status bits with write-one-to-clear, set wins over clear
`timescale 1ns/10ps
module cic_evt_status
	import cic_pkg::*;
#(
	parameter int N = 4
)(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire logic [N-1:0] set,
	input  wire logic [N-1:0] clr,
	output logic      [N-1:0] status
);
	genvar i;
	// a clear and an event in the same cycle leave the bit set
	generate
		for (i = 0; i < N; i++)
		begin : g_bit
			logic bit_r;
			logic bit_nxt;
			assign bit_nxt = set[i] | (bit_r & ~clr[i]);
			always_ff @(posedge clk or negedge rstn)
			begin
				if (!rstn)
					bit_r <= 1'b0;
				else
					bit_r <= bit_nxt;
			end
			assign status[i] = bit_r;
		end
	endgenerate
endmodule // cic_evt_status

// ===== logic/cic_pin_sync.sv
// two-stage synchroniser with edge detector for the external interrupt pin
`timescale 1ns/10ps
module cic_pin_sync
	import cic_pkg::*;
#(
	parameter bit RISING = 1'b1
)(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic pin,
	output logic      edge_pulse
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// meta_r feeds only sync_r; the edge detector looks at later stages
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end
		else
		begin
			meta_r <= pin;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// one-cycle pulse on the selected edge
	assign edge_pulse = RISING ? (sync_r & ~last_r) : (~sync_r & last_r);
endmodule // cic_pin_sync

// ===== logic/cic_pkg.sv
// types shared by the interrupt control block
package cic_pkg;
	typedef enum logic [2:0] {
		CIC_SEL_NONE,
		CIC_SEL_CTRL,
		CIC_SEL_STAT,
		CIC_SEL_CLR,
		CIC_SEL_EN
	} cic_sel_t;
endpackage

// ===== logic/cic_regs.svh
// register offsets, field positions, reset values and counts for the interrupt control block
// Summary of operation
// - interrupt control register is read/write and answers at 0x0b and 0x8b alike
// - register holds enable and flag for timer overflow, port change, external pin
// - port change and external pin requests are routed through this register with timer
// - a source sets its flag whenever its event occurs, regardless of any enable
// - at reset bits 7..1 are zero; bit 0 (port change flag) is undefined, here reset to zero as well
`ifndef CIC_REGS_SVH
`define CIC_REGS_SVH

`define CIC_ADDR_W        8
`define CIC_DATA_W        8
`define CIC_ADDR_CTRL_LO  8'h0b
`define CIC_ADDR_CTRL_HI  8'h8b
`define CIC_ADDR_STAT     8'h40
`define CIC_ADDR_CLR      8'h41
`define CIC_ADDR_EN       8'h42

`define CIC_B_GLOBAL_EN   7
`define CIC_B_PERIPH_EN   6
`define CIC_B_TMR_EN      5
`define CIC_B_EXT_EN      4
`define CIC_B_PORT_EN     3
`define CIC_B_TMR_FLAG    2
`define CIC_B_EXT_FLAG    1
`define CIC_B_PORT_FLAG   0

`define CIC_CTRL_RESET    8'h00
`define CIC_EVT_N         4
`define CIC_EVT_RESET     4'h0
`define CIC_E_TMR         0
`define CIC_E_EXT         1
`define CIC_E_PORT        2
`define CIC_E_REQ         3
`define CIC_SYNC_STAGES   2

`endif

// ===== logic/cic_top.sv
// interrupt control register with request combiner and event status block
`timescale 1ns/10ps
`include "cic_regs.svh"
module cic_top
	import cic_pkg::*;
#(
	parameter bit EXT_RISING = 1'b1
)(
	input  wire logic                    CLK,
	input  wire logic                    RSTN,
	input  wire logic [`CIC_ADDR_W-1:0]  ADDR,
	input  wire logic [`CIC_DATA_W-1:0]  WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output logic      [`CIC_DATA_W-1:0]  RDATA,
	input  wire logic                    TMR_OVF,
	input  wire logic                    PORT_CHANGE,
	input  wire logic                    EXT_PIN,
	input  wire logic                    PERIPH_REQ,
	output logic                         CORE_REQ,
	output logic                         IRQ
);
	// reset release synchroniser
	logic rst_meta_r;
	logic rstn_s;

	// registers
	logic [`CIC_DATA_W-1:0] ctrl_r;
	logic [`CIC_DATA_W-1:0] ctrl_nxt;
	logic [`CIC_EVT_N-1:0]  evt_en_r;
	logic [`CIC_EVT_N-1:0]  evt_en_nxt;
	logic [`CIC_DATA_W-1:0] rdata_r;
	logic [`CIC_DATA_W-1:0] rdata_nxt;
	logic                   req_r;
	logic                   req_nxt;

	// decode and event wires
	cic_sel_t               wr_sel;
	cic_sel_t               rd_sel;
	logic                   wr_ctrl;
	logic                   wr_clr;
	logic                   wr_en;
	logic                   ext_edge;
	logic [`CIC_DATA_W-1:0] flag_set;
	logic [`CIC_DATA_W-1:0] flag_mask;
	logic [`CIC_EVT_N-1:0]  evt_set;
	logic [`CIC_EVT_N-1:0]  evt_clr;
	logic [`CIC_EVT_N-1:0]  evt_stat;
	logic [`CIC_DATA_W-1:0] rd_value;

	// field views of the control register
	logic global_irq_enable;
	logic peripheral_group_enable;
	logic timer_overflow_enable;
	logic external_pin_enable;
	logic port_change_enable;
	logic timer_overflow_flag;
	logic external_pin_irq_flag;
	logic port_change_flag;

	// address decode shared by the read and write paths
	function automatic cic_sel_t cic_decode(input logic [`CIC_ADDR_W-1:0] a);
		cic_sel_t s;
		s = CIC_SEL_NONE;
		if (a == `CIC_ADDR_CTRL_LO || a == `CIC_ADDR_CTRL_HI)
			s = CIC_SEL_CTRL;
		else if (a == `CIC_ADDR_STAT)
			s = CIC_SEL_STAT;
		else if (a == `CIC_ADDR_CLR)
			s = CIC_SEL_CLR;
		else if (a == `CIC_ADDR_EN)
			s = CIC_SEL_EN;
		return s;
	endfunction

	// the rest of the design sees reset leave only on a clock edge
	always_ff @(posedge CLK or negedge RSTN)
	begin
		if (!RSTN)
		begin
			rst_meta_r <= 1'b0;
			rstn_s     <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rstn_s     <= rst_meta_r;
		end
	end

	// external pin passes two flops before the edge detector
	cic_pin_sync #(
		.RISING (EXT_RISING)
	) u_ext_sync (
		.clk        (CLK),
		.rstn       (rstn_s),
		.pin        (EXT_PIN),
		.edge_pulse (ext_edge)
	);

	// bus decode
	assign wr_sel  = WR ? cic_decode(ADDR) : CIC_SEL_NONE;
	assign rd_sel  = RD ? cic_decode(ADDR) : CIC_SEL_NONE;
	assign wr_ctrl = (wr_sel == CIC_SEL_CTRL);
	assign wr_clr  = (wr_sel == CIC_SEL_CLR);
	assign wr_en   = (wr_sel == CIC_SEL_EN);

	// field views
	assign global_irq_enable       = ctrl_r[`CIC_B_GLOBAL_EN];
	assign peripheral_group_enable = ctrl_r[`CIC_B_PERIPH_EN];
	assign timer_overflow_enable   = ctrl_r[`CIC_B_TMR_EN];
	assign external_pin_enable     = ctrl_r[`CIC_B_EXT_EN];
	assign port_change_enable      = ctrl_r[`CIC_B_PORT_EN];
	assign timer_overflow_flag     = ctrl_r[`CIC_B_TMR_FLAG];
	assign external_pin_irq_flag   = ctrl_r[`CIC_B_EXT_FLAG];
	assign port_change_flag        = ctrl_r[`CIC_B_PORT_FLAG];

	// source events land in their flags with no regard to any enable
	always_comb
	begin
		flag_set = '0;
		flag_set[`CIC_B_TMR_FLAG]  = TMR_OVF;
		flag_set[`CIC_B_EXT_FLAG]  = ext_edge;
		flag_set[`CIC_B_PORT_FLAG] = PORT_CHANGE;
	end

	// a write replaces the register, but an event in the same cycle still sets its flag;
	// flags otherwise hold until software writes them
	assign flag_mask = flag_set;
	assign ctrl_nxt  = (wr_ctrl ? WDATA : ctrl_r) | flag_mask;

	// request combiner: peripheral group only counts with its own enable
	assign req_nxt = global_irq_enable &
		((timer_overflow_enable & timer_overflow_flag) |
		 (external_pin_enable & external_pin_irq_flag) |
		 (port_change_enable & port_change_flag) |
		 (peripheral_group_enable & PERIPH_REQ));

	// control register and request flop; bit 0 resets to zero as a safe pick
	always_ff @(posedge CLK or negedge rstn_s)
	begin
		if (!rstn_s)
		begin
			ctrl_r <= `CIC_CTRL_RESET;
			req_r  <= 1'b0;
		end
		else
		begin
			ctrl_r <= ctrl_nxt;
			req_r  <= req_nxt;
		end
	end

	assign CORE_REQ = req_r;

	// event status: source flag sets and the rise of the core request
	always_comb
	begin
		evt_set = '0;
		evt_set[`CIC_E_TMR]  = TMR_OVF;
		evt_set[`CIC_E_EXT]  = ext_edge;
		evt_set[`CIC_E_PORT] = PORT_CHANGE;
		evt_set[`CIC_E_REQ]  = req_nxt & ~req_r;
	end

	assign evt_clr    = wr_clr ? WDATA[`CIC_EVT_N-1:0] : '0;
	assign evt_en_nxt = wr_en ? WDATA[`CIC_EVT_N-1:0] : evt_en_r;

	cic_evt_status #(
		.N (`CIC_EVT_N)
	) u_evt (
		.clk    (CLK),
		.rstn   (rstn_s),
		.set    (evt_set),
		.clr    (evt_clr),
		.status (evt_stat)
	);

	// status enable register
	always_ff @(posedge CLK or negedge rstn_s)
	begin
		if (!rstn_s)
			evt_en_r <= `CIC_EVT_RESET;
		else
			evt_en_r <= evt_en_nxt;
	end

	// level interrupt while any enabled status bit is set
	assign IRQ = |(evt_stat & evt_en_r);

	// read mux; clear register is write-only and unmapped addresses read zero
	always_comb
	begin
		rd_value = '0;
		if (rd_sel == CIC_SEL_CTRL)
			rd_value = ctrl_r;
		else if (rd_sel == CIC_SEL_STAT)
			rd_value[`CIC_EVT_N-1:0] = evt_stat;
		else if (rd_sel == CIC_SEL_EN)
			rd_value[`CIC_EVT_N-1:0] = evt_en_r;
	end

	// read data stand only in the cycle after the strobe, zero otherwise
	assign rdata_nxt = RD ? rd_value : '0;

	always_ff @(posedge CLK or negedge rstn_s)
	begin
		if (!rstn_s)
			rdata_r <= '0;
		else
			rdata_r <= rdata_nxt;
	end

	assign RDATA = rdata_r;

	// ------------------------------------------------------------------
	// checks
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rstn_s);

	sequence s_rd_ctrl;
		RD && (cic_decode(ADDR) == CIC_SEL_CTRL);
	endsequence

	sequence s_wr_ctrl_low;
		WR && (ADDR == `CIC_ADDR_CTRL_LO);
	endsequence

	sequence s_wr_ctrl_high;
		WR && (ADDR == `CIC_ADDR_CTRL_HI);
	endsequence

	// both aliases reach the same register
	a_alias_write_low: assert property (
		s_wr_ctrl_low ##1 !WR [*1] |-> ctrl_r == ($past(WDATA) | $past(flag_set)))
		else $error("write at low alias not stored");

	a_alias_read_high: assert property (
		s_wr_ctrl_high ##1 (RD && ADDR == `CIC_ADDR_CTRL_LO && !WR)
		|=> RDATA == ($past(WDATA, 2) | $past(flag_set, 2)))
		else $error("high alias write not read back at low alias");

	a_read_once: assert property (
		s_rd_ctrl ##1 !RD |=> RDATA == '0)
		else $error("read data outlived its cycle");

	a_timer_flag_set: assert property (
		TMR_OVF |=> timer_overflow_flag)
		else $error("timer overflow did not set its flag");

	a_ext_flag_set: assert property (
		ext_edge && !external_pin_enable |=> external_pin_irq_flag)
		else $error("external pin edge lost with its enable clear");

	a_port_set_wins: assert property (
		PORT_CHANGE && wr_ctrl && !WDATA[`CIC_B_PORT_FLAG] |=> port_change_flag)
		else $error("port change lost against a clearing write");

	a_flags_hold: assert property (
		!wr_ctrl ##1 !wr_ctrl |->
			(ctrl_r[`CIC_B_TMR_FLAG:0] & $past(ctrl_r[`CIC_B_TMR_FLAG:0]))
			== $past(ctrl_r[`CIC_B_TMR_FLAG:0]))
		else $error("flag dropped without a software write");

	a_req_global_off: assert property (
		!global_irq_enable ##1 !global_irq_enable |-> !CORE_REQ)
		else $error("core request with global enable clear");

	a_req_timer: assert property (
		global_irq_enable && timer_overflow_enable && timer_overflow_flag |=> CORE_REQ)
		else $error("enabled timer flag did not raise the request");

	a_req_periph: assert property (
		global_irq_enable && !peripheral_group_enable && PERIPH_REQ
		&& !(timer_overflow_enable && timer_overflow_flag)
		&& !(external_pin_enable && external_pin_irq_flag)
		&& !(port_change_enable && port_change_flag) |=> !CORE_REQ)
		else $error("peripheral request passed a clear group enable");

	a_reset_value: assert property (
		$rose(rstn_s) |-> ctrl_r[`CIC_B_GLOBAL_EN:`CIC_B_EXT_FLAG] == '0)
		else $error("control bits 7..1 not zero after reset");

	a_irq_follows: assert property (
		TMR_OVF && evt_en_r[`CIC_E_TMR] && !wr_en |=> IRQ)
		else $error("enabled timer event did not hold the interrupt");
endmodule // cic_top

// ===== verification/cic_core_model.sv
// processor-side model: register bus master and interrupt arming
`timescale 1ns/10ps
module cic_core_model
	import cic_pkg::*;
(
	input  wire logic       clk,
	output logic      [7:0] addr,
	output logic      [7:0] wdata,
	output logic            wr,
	output logic            rd,
	input  wire logic [7:0] rdata
);
	// bus idles with strobes low
	initial
	begin
		addr  = 8'h00;
		wdata = 8'h00;
		wr    = 1'b0;
		rd    = 1'b0;
	end

	// one-cycle write strobe, signals change just after the edge
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		wdata <= ~d;
	endtask

	// read data is only valid in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd   <= 1'b0;
		#1;
		d = rdata;
	endtask

	// write strobe followed at once by a read strobe, no idle cycle between
	task automatic wr_rd(input logic [7:0] aw, input logic [7:0] d, input logic [7:0] ar,
		output logic [7:0] q);
		@(posedge clk);
		addr  <= aw;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr    <= 1'b0;
		addr  <= ar;
		rd    <= 1'b1;
		@(posedge clk);
		rd    <= 1'b0;
		#1;
		q = rdata;
	endtask

	// stale flags are wiped before any enable goes up
	task automatic arm(input logic [7:0] en);
		wr_reg(8'h0b, 8'h00);
		wr_reg(8'h0b, en & 8'hf8);
	endtask
endmodule // cic_core_model

// ===== verification/cic_top_tb.sv
// self-checking bench for the interrupt control register block
`timescale 1ns/10ps
`include "cic_regs.svh"
`define CHK(got, exp) \
	begin checked++; if ((got) !== (exp)) begin mismatches++; \
	$display("ERROR %0t: got %h expected %h", $time, got, exp); end end
module cic_top_tb;
	logic       clk;
	logic       rstn;
	logic [7:0] addr, wdata, rdata, d;
	logic       wr, rd, core_req, irq;
	logic       tmr_ovf, port_chg, ext_pin, periph_req;
	int         mismatches = 0, checked = 0, cycles = 0;

	always #20 clk = ~clk;

	cic_top i_cic_top (.CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .TMR_OVF(tmr_ovf), .PORT_CHANGE(port_chg),
		.EXT_PIN(ext_pin), .PERIPH_REQ(periph_req), .CORE_REQ(core_req), .IRQ(irq));

	cic_core_model i_cic_core_model (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
		.rd(rd), .rdata(rdata));

	task automatic close_out();
		$display("mismatches=%0d checked=%0d", mismatches, checked);
		if (mismatches == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// a hang is stopped at cycle 3000, far past the end of the scenarios
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			close_out();
		end
	end

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask

	// reset state, then both addresses must reach the one register
	task automatic t_reset_alias();
		i_cic_core_model.rd_reg(8'h0b, d);
		`CHK(d, 8'h00)
		`CHK({core_req, irq}, 2'b00)
		i_cic_core_model.wr_reg(8'h0b, 8'h78);
		i_cic_core_model.rd_reg(8'h8b, d);
		`CHK(d, 8'h78)
		i_cic_core_model.wr_rd(8'h8b, 8'h58, 8'h0b, d);
		`CHK(d, 8'h58)
		i_cic_core_model.wr_reg(8'h8b, 8'h00);
		i_cic_core_model.rd_reg(8'h0b, d);
		`CHK(d, 8'h00)
	endtask

	// all three sources latch with every enable off and no request follows
	task automatic t_flags_no_enable();
		@(posedge clk);
		tmr_ovf  <= 1'b1;
		port_chg <= 1'b1;
		ext_pin  <= 1'b1;
		@(posedge clk);
		tmr_ovf  <= 1'b0;
		port_chg <= 1'b0;
		wait_n(5);
		ext_pin  <= 1'b0;
		i_cic_core_model.rd_reg(8'h8b, d);
		`CHK(d, 8'h07)
		`CHK(core_req, 1'b0)
		// flags stay until software writes them low
		i_cic_core_model.arm(8'h00);
		i_cic_core_model.rd_reg(8'h0b, d);
		`CHK(d, 8'h00)
		// a port change in the cycle of a clearing write must survive it
		fork
			i_cic_core_model.wr_reg(8'h0b, 8'h00);
			begin
				@(posedge clk);
				port_chg <= 1'b1;
				@(posedge clk);
				port_chg <= 1'b0;
			end
		join
		i_cic_core_model.rd_reg(8'h0b, d);
		`CHK(d, 8'h01)
		i_cic_core_model.wr_reg(8'h0b, 8'h00);
	endtask

	// an enabled flag raises the request only under the global enable
	task automatic t_request();
		i_cic_core_model.arm(8'h20);
		@(posedge clk);
		tmr_ovf <= 1'b1;
		@(posedge clk);
		tmr_ovf <= 1'b0;
		wait_n(3);
		`CHK(core_req, 1'b0)
		i_cic_core_model.wr_reg(8'h0b, 8'ha4);
		wait_n(3);
		`CHK(core_req, 1'b1)
		i_cic_core_model.arm(8'ha0);
		wait_n(3);
		`CHK(core_req, 1'b0)
		i_cic_core_model.arm(8'hc0);
		periph_req <= 1'b1;
		wait_n(3);
		`CHK(core_req, 1'b1)
		i_cic_core_model.arm(8'h80);
		wait_n(3);
		`CHK(core_req, 1'b0)
		periph_req <= 1'b0;
		i_cic_core_model.arm(8'h00);
	endtask

	// sticky status, enable, clear and the unmapped places
	task automatic t_status_irq();
		i_cic_core_model.rd_reg(8'h40, d);
		`CHK(d, 8'h0f)
		i_cic_core_model.wr_reg(8'h42, 8'h01);
		wait_n(1);
		`CHK(irq, 1'b1)
		i_cic_core_model.wr_reg(8'h42, 8'h00);
		wait_n(1);
		`CHK(irq, 1'b0)
		i_cic_core_model.wr_reg(8'h41, 8'h0f);
		i_cic_core_model.wr_reg(8'h42, 8'h0f);
		wait_n(1);
		`CHK(irq, 1'b0)
		i_cic_core_model.rd_reg(8'h41, d);
		`CHK(d, 8'h00)
		i_cic_core_model.wr_reg(8'h55, 8'hff);
		i_cic_core_model.rd_reg(8'h55, d);
		`CHK(d, 8'h00)
		i_cic_core_model.rd_reg(8'h0b, d);
		`CHK(d, 8'h00)
		// an enabled timer event raises the interrupt until its status is cleared
		@(posedge clk);
		tmr_ovf <= 1'b1;
		@(posedge clk);
		tmr_ovf <= 1'b0;
		wait_n(1);
		`CHK(irq, 1'b1)
		i_cic_core_model.wr_reg(8'h41, 8'h01);
		wait_n(1);
		`CHK(irq, 1'b0)
		i_cic_core_model.wr_reg(8'h0b, 8'h00);
	endtask

	initial
	begin
		clk        = 1'b0;
		rstn       = 1'b0;
		tmr_ovf    = 1'b0;
		port_chg   = 1'b0;
		ext_pin    = 1'b0;
		periph_req = 1'b0;
		wait_n(12);
		rstn <= 1'b1;
		wait_n(3);
		t_reset_alias();
		t_flags_no_enable();
		t_request();
		t_status_irq();
		close_out();
	end
endmodule // cic_top_tb
